//--- logic/mdcd_core.sv
// Serial command decoder with two-rank converter latches and latch readback
// What this block does
// - Word bits: register select 23..21, data 20..8, mode 7..6, channel 5..4, address 3..0.
// - Channels 4..7 decode from channel field 1x plus address bit 0.
// - Address codes 011 B, 100 C, 101 D, 110 set register; 010 reserved.
// - Address 111 with register select 000 configures; data bit 0 picks calibration rank.
// - In configuration, data bit 1 picks group-C voltage or current output.
// - Six-bit converters take data bits 12..7 and ignore bits 6..0.
// - Mode 10, channel 00, address 000x loads every converter in parallel.
// - Mode bit 0 set means set load; set number from channel bits and mode bit 1.
// - Set load moves only addressed-set converters of the chosen group.
// - Scan enable high connects the addressed converter to readback; low disconnects.
// - Readback connection follows scan enable directly, without any clock edge.
// - Readback stays disconnected whenever the parallel-load address is selected.
// - Readback selects a converter by the same address fields as writing.
// - Rank select input picks first or second rank latches for capture.
// - Scan high and shift-out control high capture the latch on a clock edge.
// - Shift-out control low shifts the readback register out one bit per edge.
module mdcd_core
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   input wire logic serialDataInput,
   input wire logic wordStrobe,
   input wire logic scanEnableInput,
   input wire logic rankSelect,
   input wire logic shiftOutControl_n,
   output logic latchReadbackOutput,
   output logic readbackConnect,
   output logic [mdcd_pkg::CONV_IDX_W-1:0] readbackIndex,
   output logic [mdcd_pkg::NUM_CONV*mdcd_pkg::DATA_W-1:0] outputLatches,
   output logic [mdcd_pkg::NUM_CH-1:0] groupCCurrent,
   output logic [mdcd_pkg::NUM_CH-1:0] calRank2
);
   localparam int CW = mdcd_pkg::DATA_W;

   // Converter index from channel and slot
   function automatic logic [mdcd_pkg::CONV_IDX_W-1:0] mdcd_idx(input logic [2:0] ch,
                                                                input logic [2:0] sl);
      mdcd_idx = 6'(ch * mdcd_pkg::NUM_SLOT + sl);
   endfunction

   // Pin synchronisers; the first stage feeds only the second
   logic [2:0] dinSync, strbSync, scanSync, rankSync, shSync;
   logic [2:0] next_dinSync, next_strbSync, next_scanSync, next_rankSync, next_shSync;
   logic [mdcd_pkg::WORD_W-1:0] shiftIn, next_shiftIn;
   logic [mdcd_pkg::WORD_W-1:0] cmdWord, next_cmdWord;
   logic cmdValid, next_cmdValid;
   logic [CW-1:0] rank1 [mdcd_pkg::NUM_CONV];
   logic [CW-1:0] next_rank1 [mdcd_pkg::NUM_CONV];
   logic [CW-1:0] rank2 [mdcd_pkg::NUM_CONV];
   logic [CW-1:0] next_rank2 [mdcd_pkg::NUM_CONV];
   logic [2:0] setReg [mdcd_pkg::NUM_CH];
   logic [2:0] next_setReg [mdcd_pkg::NUM_CH];
   logic [mdcd_pkg::NUM_CH-1:0] next_groupCCurrent, next_calRank2;
   logic [CW-1:0] readback, next_readback;
   mdcd_pkg::mdcd_word_s word;
   mdcd_pkg::mdcd_dec_s dec;
   logic strobeRise, strobeFall;
   logic [4:0] bitCount, next_bitCount;
   logic [CW-1:0] capData;
   logic [mdcd_pkg::CONV_IDX_W-1:0] wIdx;
   logic [CW-1:0] wData;
   logic shiftMode;

   assign word = mdcd_pkg::mdcd_word_s'(cmdWord);
   assign strobeRise = strbSync[1] && !strbSync[2];
   assign strobeFall = !strbSync[1] && strbSync[2];

   mdcd_decode mdcd_decode_inst
   (
      .word(word),
      .dec(dec)
   );

   assign wIdx = mdcd_idx(dec.channel, dec.slot);
   // Six-bit converters keep only the top six data bits
   assign wData = (dec.slot == mdcd_pkg::SLOT_D)
      ? {word.data[CW-1:CW-mdcd_pkg::CODE6_W], 7'h00} : word.data;
   assign readbackIndex = wIdx;

   // Analog path follows the raw pin so no clock is needed to switch it
   // The last taken word keeps its address, so the switch stays on between strobes
   assign readbackConnect = scanEnableInput && !dec.allLoad
      && !dec.setLoad && dec.slot != mdcd_pkg::SLOT_NONE;
   // Words without a converter read as zero rather than indexing past the array
   assign capData = (dec.slot == mdcd_pkg::SLOT_NONE) ? mdcd_pkg::LATCH_RST
      : (rankSync[2] ? rank2[wIdx] : rank1[wIdx]);
   assign shiftMode = !shSync[2];
   assign latchReadbackOutput = readback[CW-1];

   // Synchroniser and serial word shifter
   always_comb
   begin
      next_dinSync = {dinSync[1:0], serialDataInput};
      next_strbSync = {strbSync[1:0], wordStrobe};
      next_scanSync = {scanSync[1:0], scanEnableInput};
      next_rankSync = {rankSync[1:0], rankSelect};
      next_shSync = {shSync[1:0], shiftOutControl_n};
      next_shiftIn = shiftIn;
      next_bitCount = bitCount;
      next_cmdWord = cmdWord;
      next_cmdValid = 1'b0;
      if (strobeRise)
      begin
         next_shiftIn = {shiftIn[mdcd_pkg::WORD_W-2:0], dinSync[2]};
         next_bitCount = bitCount + 5'h01;
      end
      // Only a full word executes; a partial word would scribble over other latches
      if (strobeFall && bitCount == 5'(mdcd_pkg::WORD_W))
      begin
         next_bitCount = 5'h00;
         if (shSync[2])
         begin
            next_cmdWord = shiftIn;
            next_cmdValid = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         dinSync <= '0;
         strbSync <= '0;
         scanSync <= '0;
         rankSync <= '0;
         shSync <= 3'h7;
         shiftIn <= '0;
         bitCount <= '0;
         cmdWord <= '0;
         cmdValid <= 1'b0;
      end
      else if (clkEn)
      begin
         dinSync <= next_dinSync;
         strbSync <= next_strbSync;
         scanSync <= next_scanSync;
         rankSync <= next_rankSync;
         shSync <= next_shSync;
         shiftIn <= next_shiftIn;
         bitCount <= next_bitCount;
         cmdWord <= next_cmdWord;
         cmdValid <= next_cmdValid;
      end
   end

   // Latch ranks, set registers and channel configuration
   always_comb
   begin
      next_rank1 = rank1;
      next_rank2 = rank2;
      next_setReg = setReg;
      next_groupCCurrent = groupCCurrent;
      next_calRank2 = calRank2;
      if (cmdValid)
      begin
         if (dec.chanWrite && dec.slot != mdcd_pkg::SLOT_NONE)
         begin
            next_rank1[wIdx] = wData;
         end
         if (dec.chanWrite && word.fadr[3:1] == mdcd_pkg::FN_SETREG)
         begin
            next_setReg[dec.channel] = word.data[2:0];
         end
         if (dec.cfgWrite)
         begin
            next_calRank2[dec.channel] = word.data[0];
            next_groupCCurrent[dec.channel] = word.data[1];
         end
         for (int c = 0; c < mdcd_pkg::NUM_CH; c++)
         begin
            for (int s = 0; s < mdcd_pkg::NUM_SLOT; s++)
            begin
               if (dec.allLoad || (dec.setLoad && setReg[c] == dec.setNum
                   && 3'(s) == dec.slot))
               begin
                  next_rank2[c*mdcd_pkg::NUM_SLOT+s] = rank1[c*mdcd_pkg::NUM_SLOT+s];
               end
            end
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < mdcd_pkg::NUM_CONV; i++)
         begin
            rank1[i] <= mdcd_pkg::LATCH_RST;
            rank2[i] <= mdcd_pkg::LATCH_RST;
         end
         for (int c = 0; c < mdcd_pkg::NUM_CH; c++)
         begin
            setReg[c] <= mdcd_pkg::SETREG_RST;
         end
         groupCCurrent <= '0;
         calRank2 <= '0;
      end
      else if (clkEn)
      begin
         rank1 <= next_rank1;
         rank2 <= next_rank2;
         setReg <= next_setReg;
         groupCCurrent <= next_groupCCurrent;
         calRank2 <= next_calRank2;
      end
   end

   // Readback register: capture when scan high and shift control high, shift when shift control low, else hold
   always_comb
   begin
      next_readback = readback;
      if (scanSync[2] && !shiftMode)
      begin
         next_readback = capData;
      end
      else if (shiftMode)
      begin
         next_readback = {readback[CW-2:0], 1'b0};
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         readback <= mdcd_pkg::LATCH_RST;
      end
      else if (clkEn)
      begin
         readback <= next_readback;
      end
   end

   // Flatten second rank for the converter outputs
   always_comb
   begin
      outputLatches = '0;
      for (int i = 0; i < mdcd_pkg::NUM_CONV; i++)
      begin
         outputLatches[i*CW +: CW] = rank2[i];
      end
   end

   // Load commands never leave the readback path connected
   a_noscan_on_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (dec.allLoad || dec.setLoad) |-> !readbackConnect)
      else $error("readback connected during load");
   a_scan_off_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !scanEnableInput |-> !readbackConnect)
      else $error("readback connected without scan");
   a_write_rank1: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clkEn && cmdValid && dec.chanWrite && dec.slot != mdcd_pkg::SLOT_NONE)
      |=> rank1[$past(wIdx)] == $past(wData))
      else $error("first rank not written");
   a_all_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clkEn && cmdValid && dec.allLoad) |=> rank2[0] == $past(rank1[0]))
      else $error("parallel load missed");
   a_rank2_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clkEn && !(cmdValid && (dec.allLoad || dec.setLoad))) |=> $stable(rank2[0]))
      else $error("second rank moved without load");
   a_shift_msb: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clkEn && shiftMode) |=> latchReadbackOutput == $past(readback[CW-2]))
      else $error("readback not shifted msb first");
   a_capture_rank: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clkEn && scanSync[2] && !shiftMode) |=> readback == $past(capData))
      else $error("readback capture wrong");
   a_cfg_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clkEn && cmdValid && dec.cfgWrite) |=> groupCCurrent[$past(dec.channel)]
      == $past(word.data[1]) && calRank2[$past(dec.channel)] == $past(word.data[0]))
      else $error("configuration write lost");
   c_all_load: cover property (@(posedge sys_clk) cmdValid && dec.allLoad);
   c_set_load: cover property (@(posedge sys_clk) cmdValid && dec.setLoad);
   c_shift_out: cover property (@(posedge sys_clk) shiftMode [*3]);
endmodule

//--- logic/mdcd_decode.sv
// Combinational decoder from one command word to its target
module mdcd_decode
(
   input mdcd_pkg::mdcd_word_s word,
   output mdcd_pkg::mdcd_dec_s dec
);
   // Address to slot mapping shared by writes and set loads
   function automatic logic [2:0] mdcd_slot(input logic [3:0] fadr);
      case (fadr[3:1])
         mdcd_pkg::FN_GRP_A: mdcd_slot = fadr[1] ? mdcd_pkg::SLOT_A1 : mdcd_pkg::SLOT_A0;
         mdcd_pkg::FN_GRP_A2: mdcd_slot = mdcd_pkg::SLOT_A1;
         mdcd_pkg::FN_GRP_B: mdcd_slot = mdcd_pkg::SLOT_B;
         mdcd_pkg::FN_GRP_C: mdcd_slot = mdcd_pkg::SLOT_C;
         mdcd_pkg::FN_GRP_D: mdcd_slot = mdcd_pkg::SLOT_D;
         default: mdcd_slot = mdcd_pkg::SLOT_NONE;
      endcase
   endfunction

   // Field decode; reserved code 010 selects nothing
   always_comb
   begin
      dec = '0;
      // Channel 4..7: channel field 1x plus address bit 0
      dec.channel = {word.chan, word.fadr[0]};
      dec.slot = mdcd_slot(word.fadr);
      dec.setNum = {word.chan, word.mode[1]};
      if (word.mode[0])
      begin
         dec.setLoad = (dec.slot != mdcd_pkg::SLOT_NONE);
      end
      else if (word.mode == mdcd_pkg::MODE_ALL && word.chan == mdcd_pkg::CHAN_ALL
               && word.fadr[3:1] == mdcd_pkg::FN_GRP_A)
      begin
         dec.allLoad = 1'b1;
      end
      else if (word.mode == mdcd_pkg::MODE_CHAN)
      begin
         dec.cfgWrite = (word.fadr[3:1] == mdcd_pkg::FN_CONFIG)
            && (word.regSel == mdcd_pkg::REG_CONFIG);
         dec.chanWrite = (dec.slot != mdcd_pkg::SLOT_NONE)
            || (word.fadr[3:1] == mdcd_pkg::FN_SETREG);
      end
   end
endmodule

//--- logic/mdcd_pkg.sv
// Package: command word layout, decode codes and latch geometry for the command decoder
package mdcd_pkg;
   localparam int WORD_W = 24;
   localparam int DATA_W = 13;
   localparam int CODE6_W = 6;
   localparam int NUM_CH = 8;
   localparam int NUM_SET = 8;
   // Converter slots per channel: A0, A1, B, C, D
   localparam int NUM_SLOT = 5;
   localparam int NUM_CONV = NUM_CH * NUM_SLOT;
   localparam int CONV_IDX_W = 6;
   // Field positions inside the command word
   localparam int REG_HI = 23;
   localparam int REG_LO = 21;
   localparam int DAT_HI = 20;
   localparam int DAT_LO = 8;
   localparam int MODE_HI = 7;
   localparam int MODE_LO = 6;
   localparam int CHAN_HI = 5;
   localparam int CHAN_LO = 4;
   localparam int FADR_HI = 3;
   localparam int FADR_LO = 0;
   // Upper three function address bits
   localparam logic [2:0] FN_GRP_A = 3'h0;
   localparam logic [2:0] FN_GRP_A2 = 3'h1;
   localparam logic [2:0] FN_RSVD = 3'h2;
   localparam logic [2:0] FN_GRP_B = 3'h3;
   localparam logic [2:0] FN_GRP_C = 3'h4;
   localparam logic [2:0] FN_GRP_D = 3'h5;
   localparam logic [2:0] FN_SETREG = 3'h6;
   localparam logic [2:0] FN_CONFIG = 3'h7;
   localparam logic [1:0] MODE_CHAN = 2'h0;
   localparam logic [1:0] MODE_ALL = 2'h2;
   localparam logic [2:0] REG_CONFIG = 3'h0;
   localparam logic [1:0] CHAN_ALL = 2'h0;
   localparam logic [2:0] SLOT_A0 = 3'h0;
   localparam logic [2:0] SLOT_A1 = 3'h1;
   localparam logic [2:0] SLOT_B = 3'h2;
   localparam logic [2:0] SLOT_C = 3'h3;
   localparam logic [2:0] SLOT_D = 3'h4;
   localparam logic [2:0] SLOT_NONE = 3'h7;
   localparam logic [DATA_W-1:0] LATCH_RST = 13'h0000;
   localparam logic [2:0] SETREG_RST = 3'h0;

   // Fields of one received command word
   typedef struct packed {
      logic [2:0] regSel;
      logic [DATA_W-1:0] data;
      logic [1:0] mode;
      logic [1:0] chan;
      logic [3:0] fadr;
   } mdcd_word_s;

   // Decoded target of a word
   typedef struct packed {
      logic chanWrite;
      logic cfgWrite;
      logic allLoad;
      logic setLoad;
      logic [2:0] channel;
      logic [2:0] slot;
      logic [2:0] setNum;
   } mdcd_dec_s;
endpackage

//--- testbench/mdcd_host_model.sv
// Host controller model that shifts command words into the decoder
module mdcd_host_model
(
   input wire logic sys_clk,
   output logic serialDataInput,
   output logic wordStrobe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Serial word sender
   // ----------------------------------------
   // Each strobe phase runs past the 4-clock minimum to leave margin for the input synchronisers
   localparam int HALF_CLKS = 5;

   // Idle levels at time zero
   initial
   begin
      serialDataInput = 1'h0;
      wordStrobe = 1'h0;
   end

   // Bits go out MSB first; the data line shows the inverse bit once its hold is over
   task automatic sendWord(input mdcd_pkg::mdcd_word_s word);
      logic [mdcd_pkg::WORD_W-1:0] bits;
      bits = word;
      for (int i = mdcd_pkg::WORD_W - 1; i >= 0; i--)
      begin
         @(posedge sys_clk);
         serialDataInput <= bits[i];
         repeat (HALF_CLKS) @(posedge sys_clk);
         wordStrobe <= 1'h1;
         repeat (HALF_CLKS) @(posedge sys_clk);
         wordStrobe <= 1'h0;
         serialDataInput <= ~bits[i];
      end
      repeat (12) @(posedge sys_clk);
   endtask
endmodule

//--- testbench/tb_top.sv
// Self-checking testbench for the command decoder with latch readback
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk;
   logic sys_rst;
   logic clkEn;
   logic serialDataInput;
   logic wordStrobe;
   logic scanEnableInput;
   logic rankSelect;
   logic shiftOutControl_n;
   logic latchReadbackOutput;
   logic readbackConnect;
   logic [mdcd_pkg::CONV_IDX_W-1:0] readbackIndex;
   logic [mdcd_pkg::NUM_CONV*mdcd_pkg::DATA_W-1:0] outputLatches;
   logic [mdcd_pkg::NUM_CH-1:0] groupCCurrent;
   logic [mdcd_pkg::NUM_CH-1:0] calRank2;
   int numErrors = 0;
   int nTests = 0;
   int cycleCount = 0;

   mdcd_core mdcd_core_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn),
      .serialDataInput(serialDataInput), .wordStrobe(wordStrobe),
      .scanEnableInput(scanEnableInput), .rankSelect(rankSelect),
      .shiftOutControl_n(shiftOutControl_n), .latchReadbackOutput(latchReadbackOutput),
      .readbackConnect(readbackConnect), .readbackIndex(readbackIndex),
      .outputLatches(outputLatches), .groupCCurrent(groupCCurrent), .calRank2(calRank2));
   mdcd_host_model mdcd_host_model_inst (.sys_clk(sys_clk),
      .serialDataInput(serialDataInput), .wordStrobe(wordStrobe));

   // ----------------------------------------
   // Clock, timeout and shared tasks
   // ----------------------------------------
   // 25 MHz clock
   initial
   begin
      sys_clk = 1'h0;
      forever #20 sys_clk = ~sys_clk;
   end

   // A hung handshake must not stall the run forever
   always @(posedge sys_clk)
   begin
      cycleCount <= cycleCount + 1;
      if (cycleCount == 40000)
      begin
         numErrors++;
         endOfTest();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      nTests++;
      if (seen !== exp)
      begin
         numErrors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic endOfTest();
      $display("Comparisons %0d, mismatches %0d", nTests, numErrors);
      if (numErrors == 0 && nTests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic send(input logic [2:0] r, input logic [12:0] d, input logic [1:0] m,
                       input logic [1:0] c, input logic [3:0] a);
      mdcd_host_model_inst.sendWord({r, d, m, c, a});
   endtask

   function automatic logic [12:0] lat(input int idx);
      return outputLatches[idx*mdcd_pkg::DATA_W +: mdcd_pkg::DATA_W];
   endfunction

   // Capture with control high, then shift; the shifted stream must hold the word MSB first
   task automatic readBack(input logic rank, input logic [12:0] exp);
      logic [31:0] seen;
      bit found;
      found = 0;
      @(posedge sys_clk);
      rankSelect <= rank;
      scanEnableInput <= 1'h1;
      shiftOutControl_n <= 1'h1;
      #5 check(readbackConnect, 1'h1);
      repeat (8) @(posedge sys_clk);
      check(readbackIndex, 6'h1A);
      shiftOutControl_n <= 1'h0;
      for (int k = 0; k < 32; k++)
      begin
         @(posedge sys_clk);
         #1 seen[31-k] = latchReadbackOutput;
      end
      for (int o = 0; o < 10; o++)
         if (seen[31-o -: 13] === exp) found = 1;
      check(found, 1'h1);
      @(posedge sys_clk);
      shiftOutControl_n <= 1'h1;
      scanEnableInput <= 1'h0;
      #5 check(readbackConnect, 1'h0);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic testReset();
      check(|outputLatches, 1'h0);
      check(groupCCurrent, 8'h00);
      check(calRank2, 8'h00);
      check(readbackConnect, 1'h0);
      $display("reset test done");
   endtask

   // Channel writes stay in the first rank until a parallel load of all converters
   task automatic testChannelWrite();
      send(3'h0, 13'h1A53, 2'h0, 2'h2, 4'h3);
      send(3'h5, 13'h0F0F, 2'h0, 2'h2, 4'h2);
      send(3'h0, 13'h1111, 2'h0, 2'h2, 4'h8);
      check(lat(26), 13'h0000);
      send(3'h0, 13'h0000, 2'h2, 2'h0, 4'h1);
      check(lat(26), 13'h1A53);
      check(lat(25), 13'h0000);
      check(lat(21), 13'h0F0F);
      check(lat(23), 13'h1111);
      $display("channel write test done");
   endtask

   // Six-bit converter keeps only the top six data bits; reserved code writes nothing
   task automatic testSixBit();
      send(3'h0, 13'h1ABC, 2'h0, 2'h3, 4'hB);
      send(3'h0, 13'h1FFF, 2'h0, 2'h3, 4'h4);
      send(3'h0, 13'h0000, 2'h2, 2'h0, 4'h0);
      check(lat(39), 13'h1A80);
      for (int j = 30; j < 35; j++)
         check(lat(j), 13'h0000);
      $display("six-bit test done");
   endtask

   task automatic testConfig();
      send(3'h0, 13'h0003, 2'h0, 2'h2, 4'hE);
      check(calRank2, 8'h10);
      check(groupCCurrent, 8'h10);
      send(3'h0, 13'h0001, 2'h0, 2'h2, 4'hF);
      send(3'h0, 13'h0000, 2'h0, 2'h2, 4'hE);
      check(calRank2, 8'h20);
      check(groupCCurrent, 8'h00);
      $display("config test done");
   endtask

   // All set registers reset to set 0; wrong group or wrong set must not load
   task automatic testSetLoad();
      send(3'h0, 13'h0777, 2'h0, 2'h3, 4'h6);
      send(3'h0, 13'h0000, 2'h1, 2'h0, 4'h8);
      check(lat(32), 13'h0000);
      send(3'h0, 13'h0000, 2'h3, 2'h0, 4'h6);
      check(lat(32), 13'h0000);
      send(3'h0, 13'h0000, 2'h1, 2'h0, 4'h7);
      check(lat(32), 13'h0777);
      // Channel 6 joins set 5; a set-0 load must pass it by, a set-5 load must move it
      send(3'h0, 13'h0005, 2'h0, 2'h3, 4'hC);
      send(3'h0, 13'h0123, 2'h0, 2'h3, 4'h6);
      send(3'h0, 13'h0000, 2'h1, 2'h0, 4'h6);
      check(lat(32), 13'h0777);
      send(3'h0, 13'h0000, 2'h3, 2'h2, 4'h6);
      check(lat(32), 13'h0123);
      // A low clock enable must swallow a whole load word
      send(3'h0, 13'h0456, 2'h0, 2'h3, 4'h6);
      @(posedge sys_clk);
      clkEn <= 1'h0;
      send(3'h0, 13'h0000, 2'h3, 2'h2, 4'h6);
      clkEn <= 1'h1;
      check(lat(32), 13'h0123);
      $display("set load test done");
   endtask

   task automatic testReadback();
      send(3'h0, 13'h0C35, 2'h0, 2'h2, 4'h3);
      readBack(1'h0, 13'h0C35);
      readBack(1'h1, 13'h1A53);
      send(3'h0, 13'h0000, 2'h2, 2'h0, 4'h0);
      @(posedge sys_clk);
      scanEnableInput <= 1'h1;
      #5 check(readbackConnect, 1'h0);
      @(posedge sys_clk);
      scanEnableInput <= 1'h0;
      $display("readback test done");
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      sys_rst = 1'h1;
      clkEn = 1'h1;
      scanEnableInput = 1'h0;
      rankSelect = 1'h0;
      shiftOutControl_n = 1'h1;
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'h0;
      repeat (2) @(posedge sys_clk);
      testReset();
      testChannelWrite();
      testSixBit();
      testConfig();
      testSetLoad();
      testReadback();
      endOfTest();
   end
endmodule
